// ### design/bl_boot_loader.sv
// boot loader, program memory, data ram and port registers
`timescale 1ns/1ps
`default_nettype none

module bl_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [0:D-1];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire empty = (wp_r == rp_r);
    wire push = in_valid_in && !full;
    wire pop = out_ready_in && !empty;

    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[rp_r[AW-1:0]];

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule : bl_fifo

module bl_boot_loader
    import bl_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic [11:0] prog_addr_in,
    input wire logic prog_wr_in,
    input wire logic [7:0] prog_wdata_in,
    output logic [7:0] prog_rdata_out,
    input wire logic [7:0] iram_addr_in,
    input wire logic iram_indirect_in,
    input wire logic iram_wr_in,
    input wire logic [7:0] iram_wdata_in,
    output logic [7:0] iram_rdata_out,
    output logic [15:0] dptr_out,
    output logic cpu_run_out,
    output logic booting_out,
    input wire logic [7:0] port_zero_pin_in,
    output logic [7:0] port_zero_pin_out,
    output logic [7:0] port_zero_pin_oe_out,
    input wire logic [2:0] port_one_pin_in,
    output logic [1:0] port_one_pin_out,
    output logic [1:0] port_one_pin_oe_out
);
    // memories
    logic [7:0] prog_mem [0:PROG_BYTES-1];
    logic [7:0] iram [0:IRAM_BYTES-1];
    logic [7:0] sfr_mem [0:127];

    // pin synchronisers
    logic [7:0] p0_m_r;
    logic [7:0] p0_s_r;
    logic [2:0] p1_m_r;
    logic [2:0] p1_s_r;

    // registers
    logic [7:0] p0_r;
    logic [7:0] p1_r;
    logic [7:0] port_zero_direction_r;
    logic [7:0] port_zero_alternate_r;
    logic [7:0] port_one_direction_r;
    logic [7:0] port_one_alternate_r;
    logic [7:0] dpl_r;
    logic [7:0] dph_r;
    logic [7:0] second_pointer_low_r;
    logic [7:0] second_pointer_high_r;
    logic [7:0] dps_r;
    logic [7:0] spc_r;

    // loader state
    bl_state_e state_r;
    logic req_r;
    logic done_r;
    logic sck_r;
    logic csn_r;
    logic [4:0] div_r;
    logic [4:0] bit_r;
    logic [23:0] sh_r;
    logic [7:0] rx_r;
    logic [12:0] cnt_r;
    logic [12:0] wcnt_r;
    logic [11:0] wa_r;
    logic push_r;
    logic [7:0] push_data_r;

    // fifo wires
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;

    // register decode
    wire in_sfr = sfr_addr_in[7];
    wire wr_p0 = sfr_wr_in && (sfr_addr_in == ADDR_P0);
    wire wr_p1 = sfr_wr_in && (sfr_addr_in == ADDR_P1);
    wire wr_port_zero_direction = sfr_wr_in && (sfr_addr_in == ADDR_PORT_ZERO_DIRECTION);
    wire wr_port_zero_alternate = sfr_wr_in && (sfr_addr_in == ADDR_PORT_ZERO_ALTERNATE);
    wire wr_port_one_direction = sfr_wr_in && (sfr_addr_in == ADDR_PORT_ONE_DIRECTION);
    wire wr_port_one_alternate = sfr_wr_in && (sfr_addr_in == ADDR_PORT_ONE_ALTERNATE);
    wire wr_dpl = sfr_wr_in && (sfr_addr_in == ADDR_DPL);
    wire wr_dph = sfr_wr_in && (sfr_addr_in == ADDR_DPH);
    wire wr_second_pointer_low = sfr_wr_in && (sfr_addr_in == ADDR_SECOND_POINTER_LOW);
    wire wr_second_pointer_high = sfr_wr_in && (sfr_addr_in == ADDR_SECOND_POINTER_HIGH);
    wire wr_dps = sfr_wr_in && (sfr_addr_in == ADDR_DPS);
    wire wr_spc = sfr_wr_in && (sfr_addr_in == ADDR_SPECIAL_FUNCTION_ENABLE);
    wire special = (sfr_addr_in == ADDR_P0) || (sfr_addr_in == ADDR_P1)
        || (sfr_addr_in == ADDR_PORT_ZERO_DIRECTION) || (sfr_addr_in == ADDR_PORT_ZERO_ALTERNATE)
        || (sfr_addr_in == ADDR_PORT_ONE_DIRECTION) || (sfr_addr_in == ADDR_PORT_ONE_ALTERNATE)
        || (sfr_addr_in == ADDR_DPL) || (sfr_addr_in == ADDR_DPH)
        || (sfr_addr_in == ADDR_SECOND_POINTER_LOW) || (sfr_addr_in == ADDR_SECOND_POINTER_HIGH)
        || (sfr_addr_in == ADDR_DPS) || (sfr_addr_in == ADDR_SPECIAL_FUNCTION_ENABLE)
        || (sfr_addr_in == ADDR_RST_CAUSE);
    wire wr_generic = sfr_wr_in && in_sfr && !special;

    // boot status seen by software
    wire busy = req_r || (state_r != ST_IDLE);
    wire [7:0] status = {6'h00, done_r, busy};

    // read selection, ports read their pins
    wire [7:0] rd_sel =
        !in_sfr ? 8'h00 :
        (sfr_addr_in == ADDR_P0) ? p0_s_r :
        (sfr_addr_in == ADDR_P1) ? {5'h00, p1_s_r} :
        (sfr_addr_in == ADDR_PORT_ZERO_DIRECTION) ? port_zero_direction_r :
        (sfr_addr_in == ADDR_PORT_ZERO_ALTERNATE) ? port_zero_alternate_r :
        (sfr_addr_in == ADDR_PORT_ONE_DIRECTION) ? port_one_direction_r :
        (sfr_addr_in == ADDR_PORT_ONE_ALTERNATE) ? port_one_alternate_r :
        (sfr_addr_in == ADDR_DPL) ? dpl_r :
        (sfr_addr_in == ADDR_DPH) ? dph_r :
        (sfr_addr_in == ADDR_SECOND_POINTER_LOW) ? second_pointer_low_r :
        (sfr_addr_in == ADDR_SECOND_POINTER_HIGH) ? second_pointer_high_r :
        (sfr_addr_in == ADDR_DPS) ? dps_r :
        (sfr_addr_in == ADDR_SPECIAL_FUNCTION_ENABLE) ? spc_r :
        (sfr_addr_in == ADDR_RST_CAUSE) ? status :
        sfr_mem[sfr_addr_in[6:0]];

    // software boot request, only while running
    wire sw_boot = wr_spc && sfr_wdata_in[SPC_BOOT_BIT] && !busy;

    // serial clock divider and shifter control
    wire tick = busy && (div_r == SCK_HALF_CYC - 5'h01);
    wire stall = (state_r == ST_DATA) && !sck_r
        && (bit_r == BYTE_LAST_BIT) && !fifo_in_ready;
    wire adv = tick && !stall;
    wire miso = p1_s_r[2];
    wire [7:0] rx_nxt = {rx_r[6:0], miso};
    wire last_byte = (cnt_r == LOAD_LEN - 13'h0001);

    // program ram write arbitration, core write dropped while busy but still holds off the loader
    wire is_rom_addr = (PROG_OPTION == OPT_ROM)
        || ((PROG_OPTION == OPT_HALF_ROM) && (prog_addr_in < HALF_BASE));
    wire cpu_prog_wr = prog_wr_in && !busy && !is_rom_addr;
    wire ld_ready = !prog_wr_in;
    wire ld_wr = fifo_out_valid && ld_ready;

    // data ram, upper half indirect only
    wire iram_ok = iram_indirect_in || !iram_addr_in[7];

    // pins, boot pins owned by loader while booting
    logic [7:0] p0_oe_nxt;
    logic [7:0] p0_out_nxt;
    wire [1:0] p1_oe_nxt = busy ? 2'b11 : ~port_one_direction_r[1:0] & ~port_one_alternate_r[1:0];
    wire [1:0] p1_out_nxt = busy ? {sh_r[23], sck_r} : p1_r[1:0];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_p0
            if (gi == 0) begin : g_sel
                // always gpio, select during boot
                assign p0_oe_nxt[gi] = busy ? 1'b1 : !port_zero_direction_r[gi];
                assign p0_out_nxt[gi] = busy ? csn_r : p0_r[gi];
            end else begin : g_gpio
                assign p0_oe_nxt[gi] = !port_zero_alternate_r[gi] && !port_zero_direction_r[gi];
                assign p0_out_nxt[gi] = p0_r[gi];
            end
        end
    endgenerate

    bl_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .in_valid_in(push_r),
        .in_ready_out(fifo_in_ready),
        .in_data_in(push_data_r),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(ld_ready),
        .out_data_out(fifo_out_data)
    );

    // memories without reset
    always_ff @(posedge clock_in) begin
        if (cpu_prog_wr) begin
            prog_mem[prog_addr_in] <= prog_wdata_in;
        end else if (ld_wr) begin
            prog_mem[wa_r] <= fifo_out_data;
        end
        if (iram_wr_in && iram_ok) begin
            iram[iram_addr_in] <= iram_wdata_in;
        end
        if (wr_generic) begin
            sfr_mem[sfr_addr_in[6:0]] <= sfr_wdata_in;
        end
    end

    // input synchronisers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            p0_m_r <= 8'h00;
            p0_s_r <= 8'h00;
            p1_m_r <= 3'h0;
            p1_s_r <= 3'h0;
        end else begin
            p0_m_r <= port_zero_pin_in;
            p0_s_r <= p0_m_r;
            p1_m_r <= port_one_pin_in;
            p1_s_r <= p1_m_r;
        end
    end

    // port and pointer registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            p0_r <= PORT_RST;
            p1_r <= PORT_RST;
            port_zero_direction_r <= DIR_RST;
            port_zero_alternate_r <= ALT_RST;
            port_one_direction_r <= DIR_RST;
            port_one_alternate_r <= ALT_RST;
            dpl_r <= REG_RST;
            dph_r <= REG_RST;
            second_pointer_low_r <= REG_RST;
            second_pointer_high_r <= REG_RST;
            dps_r <= REG_RST;
            spc_r <= REG_RST;
        end else begin
            if (state_r == ST_DRAIN && wcnt_r == LOAD_LEN) begin
                p0_r[0] <= 1'b1;
                port_zero_direction_r[0] <= 1'b0;
            end else begin
                if (wr_p0) p0_r <= sfr_wdata_in;
                if (wr_port_zero_direction) port_zero_direction_r <= sfr_wdata_in;
            end
            if (wr_p1) p1_r <= sfr_wdata_in;
            if (wr_port_zero_alternate) port_zero_alternate_r <= sfr_wdata_in;
            if (wr_port_one_direction) port_one_direction_r <= sfr_wdata_in;
            if (wr_port_one_alternate) port_one_alternate_r <= sfr_wdata_in;
            if (wr_dpl) dpl_r <= sfr_wdata_in;
            if (wr_dph) dph_r <= sfr_wdata_in;
            if (wr_second_pointer_low) second_pointer_low_r <= sfr_wdata_in;
            if (wr_second_pointer_high) second_pointer_high_r <= sfr_wdata_in;
            if (wr_dps) dps_r <= sfr_wdata_in;
            if (wr_spc) begin
                // boot bit self clears
                spc_r <= sfr_wdata_in & ~(8'h01 << SPC_BOOT_BIT);
            end
        end
    end

    // loader sequencer
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            req_r <= 1'b1;
            done_r <= 1'b0;
            sck_r <= 1'b0;
            csn_r <= 1'b1;
            div_r <= 5'h00;
            bit_r <= 5'h00;
            sh_r <= 24'h000000;
            rx_r <= 8'h00;
            cnt_r <= 13'h0000;
            push_r <= 1'b0;
            push_data_r <= 8'h00;
        end else begin
            push_r <= 1'b0;
            if (sw_boot) req_r <= 1'b1;
            div_r <= tick || !busy ? 5'h00 : div_r + 5'h01;
            case (state_r)
                ST_IDLE: begin
                    if (req_r && LOAD_LEN == 13'h0000) begin
                        req_r <= 1'b0;
                        done_r <= 1'b1;
                    end else if (req_r) begin
                        req_r <= 1'b0;
                        done_r <= 1'b0;
                        state_r <= ST_SEL;
                        csn_r <= 1'b0;
                        sck_r <= 1'b0;
                        sh_r <= {EE_READ_CMD, 4'h0, LOAD_BASE};
                        bit_r <= CMD_LAST_BIT;
                        cnt_r <= 13'h0000;
                    end
                end
                ST_SEL: begin
                    if (tick) state_r <= ST_CMD;
                end
                ST_CMD: begin
                    if (adv) begin
                        sck_r <= !sck_r;
                        if (sck_r) begin
                            sh_r <= {sh_r[22:0], 1'b0};
                            if (bit_r == 5'h00) begin
                                state_r <= ST_DATA;
                                bit_r <= BYTE_LAST_BIT;
                            end else begin
                                bit_r <= bit_r - 5'h01;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (adv) begin
                        sck_r <= !sck_r;
                        if (sck_r) begin
                            rx_r <= rx_nxt;
                            if (bit_r == 5'h00) begin
                                push_r <= 1'b1;
                                push_data_r <= rx_nxt;
                                cnt_r <= cnt_r + 13'h0001;
                                bit_r <= BYTE_LAST_BIT;
                                if (last_byte) begin
                                    state_r <= ST_DRAIN;
                                    csn_r <= 1'b1;
                                end
                            end else begin
                                bit_r <= bit_r - 5'h01;
                            end
                        end
                    end
                end
                ST_DRAIN: begin
                    if (wcnt_r == LOAD_LEN) begin
                        state_r <= ST_IDLE;
                        done_r <= 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // program ram fill address
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wa_r <= LOAD_BASE;
            wcnt_r <= 13'h0000;
        end else if (state_r == ST_IDLE && req_r) begin
            wa_r <= LOAD_BASE;
            wcnt_r <= 13'h0000;
        end else if (ld_wr) begin
            wa_r <= wa_r + 12'h001;
            wcnt_r <= wcnt_r + 13'h0001;
        end
    end

    // registered outputs
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sfr_rdata_out <= 8'h00;
            prog_rdata_out <= 8'h00;
            iram_rdata_out <= 8'h00;
            dptr_out <= 16'h0000;
            cpu_run_out <= 1'b0;
            booting_out <= 1'b1;
            port_zero_pin_out <= 8'h00;
            port_zero_pin_oe_out <= 8'h00;
            port_one_pin_out <= 2'h0;
            port_one_pin_oe_out <= 2'h0;
        end else begin
            if (sfr_rd_in) sfr_rdata_out <= rd_sel;
            prog_rdata_out <= prog_mem[prog_addr_in];
            iram_rdata_out <= iram_ok ? iram[iram_addr_in] : 8'h00;
            dptr_out <= dps_r[DPS_SEL_BIT] ? {second_pointer_high_r, second_pointer_low_r}
                : {dph_r, dpl_r};
            cpu_run_out <= !busy;
            booting_out <= busy;
            port_zero_pin_out <= p0_out_nxt;
            port_zero_pin_oe_out <= p0_oe_nxt;
            port_one_pin_out <= p1_out_nxt;
            port_one_pin_oe_out <= p1_oe_nxt;
        end
    end
endmodule : bl_boot_loader
`default_nettype wire

// ### design/bl_pkg.sv
// constants and types for the boot loader and memory map block
package bl_pkg;
    // clock and link timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int LINK_PERIOD_NS = 160;
    localparam int SCK_HALF_CYC_I = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [4:0] SCK_HALF_CYC =
        5'(SCK_HALF_CYC_I < 1 ? 1 : SCK_HALF_CYC_I);
    // core figures
    localparam int INSN_MIN_CYC = 4;
    localparam int INSN_MAX_CYC = 20;
    localparam int EXTRA_IRQ_SOURCES = 3;
    localparam int TIMER_COUNT = 3;
    localparam int POINTER_COUNT = 2;
    localparam int BOOT_ROM_BYTES = 512;
    localparam int IRAM_BYTES = 256;
    // special function register addresses
    localparam logic [7:0] ADDR_P0 = 8'h80;
    localparam logic [7:0] ADDR_DPL = 8'h82;
    localparam logic [7:0] ADDR_DPH = 8'h83;
    localparam logic [7:0] ADDR_SECOND_POINTER_LOW = 8'h84;
    localparam logic [7:0] ADDR_SECOND_POINTER_HIGH = 8'h85;
    localparam logic [7:0] ADDR_DPS = 8'h86;
    localparam logic [7:0] ADDR_SPECIAL_FUNCTION_ENABLE = 8'h8f;
    localparam logic [7:0] ADDR_P1 = 8'h90;
    localparam logic [7:0] ADDR_PORT_ZERO_DIRECTION = 8'h94;
    localparam logic [7:0] ADDR_PORT_ZERO_ALTERNATE = 8'h95;
    localparam logic [7:0] ADDR_PORT_ONE_DIRECTION = 8'h96;
    localparam logic [7:0] ADDR_PORT_ONE_ALTERNATE = 8'h97;
    localparam logic [7:0] ADDR_RST_CAUSE = 8'hb1;
    // field positions
    localparam int SPC_BOOT_BIT = 0;
    localparam int DPS_SEL_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    // reset values
    localparam logic [7:0] PORT_RST = 8'hff;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] ALT_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;
    // program memory build options
    typedef enum {OPT_RAM, OPT_HALF_ROM, OPT_ROM} bl_opt_e;
    localparam bl_opt_e PROG_OPTION = OPT_RAM;
    localparam logic [11:0] HALF_BASE = 12'h800;
    localparam logic [11:0] LOAD_BASE =
        (PROG_OPTION == OPT_HALF_ROM) ? HALF_BASE : 12'h000;
    localparam logic [12:0] LOAD_LEN =
        (PROG_OPTION == OPT_RAM) ? 13'h1000 :
        (PROG_OPTION == OPT_HALF_ROM) ? 13'h0800 : 13'h0000;
    localparam int PROG_BYTES = 4096;
    // serial memory read sequence
    localparam logic [7:0] EE_READ_CMD = 8'h03;
    localparam logic [4:0] CMD_LAST_BIT = 5'h17;
    localparam logic [4:0] BYTE_LAST_BIT = 5'h07;
    // buffer shape
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;
    typedef enum {ST_IDLE, ST_SEL, ST_CMD, ST_DATA, ST_DRAIN} bl_state_e;
endpackage : bl_pkg

// ### sim/bl_boot_loader_properties.sv
// concurrent checks on the boot loader top ports
`timescale 1ns/1ps
`default_nettype none
module bl_boot_loader_properties (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic [7:0] iram_addr_in,
    input wire logic iram_indirect_in,
    input wire logic [7:0] iram_rdata_out,
    input wire logic cpu_run_out,
    input wire logic booting_out,
    input wire logic [7:0] port_zero_pin_out,
    input wire logic [7:0] port_zero_pin_oe_out,
    input wire logic [1:0] port_one_pin_out,
    input wire logic [1:0] port_one_pin_oe_out
);
    logic [1:0] up_r;
    logic sck;
    assign sck = port_one_pin_out[0];
    // counts edges since reset release, saturating
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    run_excl_a: assert property (!(cpu_run_out && booting_out))
        else $error("core runs while loader busy");
    boot_pins_a: assert property (up_r == 2'h3 && booting_out |->
        port_zero_pin_oe_out[0] && (&port_one_pin_oe_out))
        else $error("boot pins not driven during boot");
    csn_frame_a: assert property (booting_out && sck |->
        !port_zero_pin_out[0]) else $error("clock while select high");
    mosi_hold_a: assert property (up_r == 2'h3 && booting_out && sck
        && $past(sck) |-> $stable(port_one_pin_out[1]))
        else $error("data to memory moved while clock high");
    sck_high_a: assert property (up_r == 2'h3 && booting_out && $rose(sck)
        |-> ##15 sck ##1 !sck) else $error("clock high time wrong");
    low_sfr_a: assert property (sfr_rd_in && !sfr_addr_in[7] |=>
        sfr_rdata_out == 8'h00) else $error("read below sfr space");
    p1_read_a: assert property (sfr_rd_in && sfr_addr_in == 8'h90 |=>
        sfr_rdata_out[7:3] == 5'h00) else $error("port one upper bits");
    rdata_hold_a: assert property (up_r == 2'h3 && !$past(sfr_rd_in)
        |-> $stable(sfr_rdata_out)) else $error("read data moved");
    iram_upper_a: assert property (iram_addr_in[7] && !iram_indirect_in
        |=> iram_rdata_out == 8'h00) else $error("direct upper ram read");
    status_busy_a: assert property (sfr_rd_in && sfr_addr_in == 8'hb1
        && booting_out ##1 booting_out |-> sfr_rdata_out[0])
        else $error("status busy bit low during boot");
    cover property (booting_out && $fell(port_zero_pin_out[0]));
    cover property (booting_out && $rose(sck));
    cover property (iram_addr_in[7] && !iram_indirect_in);
    cover property (sfr_rd_in && sfr_addr_in == 8'hb1);
endmodule : bl_boot_loader_properties
bind bl_boot_loader bl_boot_loader_properties u_props (.*);
`default_nettype wire

// ### sim/bl_boot_loader_test.sv
// self-checking bench for the boot loader
`timescale 1ns/1ps
`default_nettype none
module bl_boot_loader_test import bl_pkg::*;;
    typedef struct {
        logic [7:0] a;
        logic [7:0] w;
        logic wr;
        logic [7:0] m;
        logic [7:0] e;
    } bl_row_s;
    logic clk, rst, swr, srd, pwr, iind, iwr, run, boot, so;
    logic [7:0] sa, sw, sr, pw, pr, ia, iw, ir;
    logic [7:0] p0_out, p0_oe, p0_ext, p0_w;
    logic [1:0] p1_out, p1_oe, p1_ext;
    logic [2:0] p1_w;
    logic [11:0] pa;
    logic [15:0] dptr, nb;
    logic [23:0] cmd;
    int failures, n_checks, i;
    bl_row_s rows [10];
    assign p0_w = (p0_oe & p0_out) | (~p0_oe & p0_ext);
    assign p1_w = {so, (p1_oe & p1_out) | (~p1_oe & p1_ext)};
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    bl_boot_loader dut (.clock_in(clk), .rst_in(rst),
        .sfr_addr_in(sa), .sfr_wr_in(swr), .sfr_rd_in(srd),
        .sfr_wdata_in(sw), .sfr_rdata_out(sr), .prog_addr_in(pa),
        .prog_wr_in(pwr), .prog_wdata_in(pw), .prog_rdata_out(pr),
        .iram_addr_in(ia), .iram_indirect_in(iind), .iram_wr_in(iwr),
        .iram_wdata_in(iw), .iram_rdata_out(ir), .dptr_out(dptr),
        .cpu_run_out(run), .booting_out(boot),
        .port_zero_pin_in(p0_w), .port_zero_pin_out(p0_out),
        .port_zero_pin_oe_out(p0_oe), .port_one_pin_in(p1_w),
        .port_one_pin_out(p1_out), .port_one_pin_oe_out(p1_oe));
    bl_eeprom_model #(.SO_DELAY_NS(3)) u_mem (
        .active_low_select_in(p0_w[0]), .sck_in(p1_w[0]),
        .si_in(p1_w[1]), .so_out(so), .cmd_out(cmd), .nbytes_out(nb));
    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bound(input logic bad);
        chk(24'(bad), 24'h0);
        if (bad) report_and_stop();
    endtask : bound
    task automatic sfr(input logic [7:0] a, w, input logic wr);
        @(posedge clk);
        sa <= a;
        sw <= w;
        swr <= wr;
        srd <= !wr;
        @(posedge clk);
        swr <= 1'b0;
        srd <= 1'b0;
        #1;
    endtask : sfr
    task automatic iram(input logic [7:0] a, w, input logic ind, wr);
        @(posedge clk);
        ia <= a;
        iw <= w;
        iind <= ind;
        iwr <= wr;
        @(posedge clk);
        iwr <= 1'b0;
        #1;
    endtask : iram
    task automatic prog(input logic [11:0] a, input logic [7:0] w,
                        input logic wr);
        @(posedge clk);
        pa <= a;
        pw <= w;
        pwr <= wr;
        @(posedge clk);
        pwr <= 1'b0;
        #1;
    endtask : prog
    task automatic wait_select();
        for (i = 0; i < 100 && p0_w[0] !== 1'b0; i++) @(posedge clk);
        bound(p0_w[0] !== 1'b0);
    endtask : wait_select
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {sa, sw, swr, srd, pa, pw, pwr, ia, iw, iind, iwr} = '0;
        p0_ext = 8'h6b;
        p1_ext = 2'b00;
        failures = 0;
        n_checks = 0;
        rows = '{'{8'h84, 8'ha5, 1, 8'hff, 8'ha5},
            '{8'h85, 8'h3c, 1, 8'hff, 8'h3c}, '{8'h82, 8'h11, 1, 8'hff, 8'h11},
            '{8'h83, 8'h22, 1, 8'hff, 8'h22}, '{8'h8f, 8'h01, 1, 8'h01, 8'h00},
            '{8'h40, 8'h77, 1, 8'hff, 8'h00}, '{8'h90, 8'h00, 0, 8'hf8, 8'h00},
            '{8'h80, 8'h00, 0, 8'hfe, 8'h6a}, '{8'hb1, 8'h00, 0, 8'h03, 8'h01},
            '{8'ha0, 8'h5a, 1, 8'hff, 8'h5a}};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wait_select();
        chk(p0_oe, 8'h01);
        chk(p1_oe, 2'b11);
        chk({run, boot}, 2'b01);
        foreach (rows[k]) begin
            if (rows[k].wr) sfr(rows[k].a, rows[k].w, 1'b1);
            sfr(rows[k].a, 8'h00, 1'b0);
            chk(sr & rows[k].m, rows[k].e);
        end
        sfr(8'h86, 8'h01, 1'b1);
        repeat (2) @(posedge clk);
        #1 chk(dptr, 16'h3ca5);
        sfr(8'h86, 8'h00, 1'b1);
        repeat (2) @(posedge clk);
        #1 chk(dptr, 16'h2211);
        iram(8'h85, 8'h99, 1'b1, 1'b1);
        iram(8'h85, 8'h00, 1'b1, 1'b0);
        chk(ir, 8'h99);
        iram(8'h85, 8'h00, 1'b0, 1'b0);
        chk(ir, 8'h00);
        iram(8'h10, 8'h42, 1'b0, 1'b1);
        iram(8'h10, 8'h00, 1'b0, 1'b0);
        chk(ir, 8'h42);
        // a full image is a million cycles; the first bytes are checked
        for (i = 0; i < 12000 && nb < 16'd24; i++) @(posedge clk);
        bound(nb < 16'd24);
        chk(cmd, 24'h030000);
        prog(12'h002, 8'ha7, 1'b1);
        for (int k = 0; k < 16; k++) begin
            prog(k[11:0], 8'h00, 1'b0);
            chk(pr, 8'(k) ^ 8'h5a);
        end
        chk({run, boot}, 2'b01);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk({p0_oe, p1_oe, run}, 11'h0);
        @(posedge clk);
        rst <= 1'b0;
        wait_select();
        for (i = 0; i < 2000 && nb < 16'd1; i++) @(posedge clk);
        bound(nb < 16'd1);
        chk(cmd, 24'h030000);
        report_and_stop();
    end
endmodule : bl_boot_loader_test
`default_nettype wire

// ### sim/bl_eeprom_model.sv
// serial memory model answering read commands in mode 0
`timescale 1ns/1ps
`default_nettype none
module bl_eeprom_model #(
    parameter int SO_DELAY_NS = 0
) (
    input wire logic active_low_select_in,
    input wire logic sck_in,
    input wire logic si_in,
    output logic so_out,
    output logic [23:0] cmd_out,
    output logic [15:0] nbytes_out
);
    logic [15:0] nbits;
    logic [15:0] idx;
    logic [7:0] cur;
    logic so_r;
    initial begin
        nbits = 16'h0000;
        cmd_out = 24'h000000;
        so_r = 1'b0;
    end
    assign idx = nbits - 16'd24;
    assign cur = 8'(cmd_out[15:0] + (idx >> 3)) ^ 8'h5a;
    assign nbytes_out = nbits >= 16'd24 ? idx >> 3 : 16'h0000;
    // command shifted in msb first on rising clock
    always @(negedge active_low_select_in or posedge sck_in) begin
        if (!sck_in) begin
            nbits = 16'h0000;
            cmd_out = 24'h000000;
        end else if (!active_low_select_in) begin
            if (nbits < 16'd24) cmd_out = {cmd_out[22:0], si_in};
            nbits = nbits + 16'd1;
        end
    end
    // data out on falling clock; released line flips
    always @(negedge sck_in or posedge active_low_select_in) begin
        if (active_low_select_in) so_r = ~so_r;
        else if (nbits >= 16'd24) so_r = cur[3'd7 - idx[2:0]];
    end
    assign #(SO_DELAY_NS) so_out = so_r;
endmodule : bl_eeprom_model
`default_nettype wire
